// >>> src/cdhp_map.svh
`ifndef CDHP_MAP_SVH
`define CDHP_MAP_SVH
// Register byte offsets on the control bus.
`define CDHP_OFS_CMD_DATA   12'h000
`define CDHP_OFS_CMD_STAT   12'h004
`define CDHP_OFS_XFER_CNT   12'h008
`define CDHP_OFS_XFER_ADDR  12'h00C
`define CDHP_OFS_XFER_TRIG  12'h010
`define CDHP_OFS_XFER_STAT  12'h014
`define CDHP_OFS_IRQ_STAT   12'h018
`define CDHP_OFS_IRQ_MASK   12'h01C
`define CDHP_OFS_STAT_CTRL  12'h020
`define CDHP_OFS_STAT_BASE  12'h040
// Interrupt bit positions.
`define CDHP_IRQ_CMD        0
`define CDHP_IRQ_DONE       1
// Reset values.
`define CDHP_RST_MASK       2'h0
`define CDHP_RST_CNT        16'h0000
// Least host read spacing: 1000/2.3 ns per byte, 435 ns.
`define CDHP_READ_GAP_NS    435
`define CDHP_CLK_NS         40
`define CDHP_READ_GAP_CYC   ((`CDHP_READ_GAP_NS + `CDHP_CLK_NS - 1) / `CDHP_CLK_NS)
`endif

// >>> src/cdhp_pkg.sv
`default_nettype none
package cdhp_pkg;
    // Transfer engine states.
    typedef enum logic [2:0] {
        CDHP_IDLE,
        CDHP_FETCH,
        CDHP_OFFER,
        CDHP_HOLD,
        CDHP_GAP
    } cdhp_xfer_e;
    // Byte lane type.
    typedef logic [7:0] cdhp_byte_t;
endpackage
`default_nettype wire

// >>> src/cdhp_fifo_if.sv
`default_nettype none
// Command queue push and pop channels.
interface cdhp_fifo_if;
    logic       push;
    logic [7:0] push_data;
    logic       full;
    logic       pop;
    logic [7:0] pop_data;
    logic       empty;
    logic [3:0] count;
    modport owner (input push, push_data, pop, output full, pop_data, empty, count);
    modport user  (output push, push_data, pop, input full, pop_data, empty, count);
endinterface
`default_nettype wire

// >>> src/cdhp_cmd_fifo.sv
`default_nettype none
// Eight-deep command byte queue, order preserved.
module cdhp_cmd_fifo #(
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    // Queue channels.
    cdhp_fifo_if.owner q
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH != 8) $error("cdhp_cmd_fifo: depth must be 8");
    end
    // Pointer and count state in one struct; the storage array stays outside it.
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } cdhp_fifo_s;
    cdhp_fifo_s s_r;
    cdhp_fifo_s s_nxt;
    logic [7:0] mem [DEPTH];
    logic       do_push;
    logic       do_pop;
    // Pushes while full are dropped, pops while empty are ignored.
    assign do_push = q.push && (s_r.cnt != (AW+1)'(DEPTH));
    assign do_pop  = q.pop && (s_r.cnt != '0);
    assign q.full     = (s_r.cnt == (AW+1)'(DEPTH));
    assign q.empty    = (s_r.cnt == '0);
    assign q.pop_data = mem[s_r.rp];
    assign q.count    = 4'(s_r.cnt);
    // Pointer update.
    always_comb begin
        s_nxt = s_r;
        if (do_push) begin
            s_nxt.wp = s_r.wp + 1'b1;
        end
        if (do_pop) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        s_nxt.cnt = s_r.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    // Storage writes, no reset needed.
    always_ff @(posedge clk_sys_i) begin
        if (do_push) begin
            mem[s_r.wp] <= q.push_data;
        end
    end
endmodule
`default_nettype wire

// >>> src/cdhp_host_port.sv
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`default_nettype none
`include "cdhp_map.svh"
module cdhp_host_port #(
    parameter int STAT_BYTES = 12,
    parameter int BUF_AW     = 16
) (
    // Clock and reset.
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // AXI4-Lite slave.
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Interrupt to the controller.
    output logic             irq_o,
    // Host pins.
    input  wire logic        host_write_strobe_n_i,
    input  wire logic        host_read_strobe_n_i,
    input  wire logic        command_data_select_i,
    input  wire logic        request_mode_select_i,
    input  wire logic [7:0]  host_data_i,
    output logic [7:0]       host_data_o,
    output logic             host_data_oe_n_o,
    output logic             data_phase_active_n_o,
    output logic             throttle_or_request_out_o,
    output logic             last_byte_marker_n_o,
    output logic             status_ready_n_o,
    // Buffer RAM read port, shared by the arbiter.
    output logic [BUF_AW-1:0] buf_addr_o,
    output logic             buf_req_o,
    input  wire logic        buf_gnt_i,
    input  wire logic [7:0]  buf_data_i
);
    localparam int SW = $clog2(STAT_BYTES);
    localparam int GAP_CYC = `CDHP_READ_GAP_CYC;
    initial begin
        if (STAT_BYTES != 12) $error("cdhp_host_port: status area is 12 bytes");
        if (BUF_AW < 16) $error("cdhp_host_port: buffer needs 16 address bits");
    end

    // Register address decode, shared by write and read paths.
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        return a[11:2] == ofs[11:2];
    endfunction

    // All state of the port in one struct.
    typedef struct packed {
        logic [2:0]              wsync;
        logic [2:0]              rsync;
        logic [1:0]              csync;
        logic [1:0]              msync;
        logic [7:0]              hd1;
        logic [7:0]              hd2;
        logic                    aw_got;
        logic [11:0]             aw_a;
        logic                    w_got;
        logic [31:0]             w_d;
        logic [1:0]              w_s;
        logic                    bvalid;
        logic                    rvalid;
        logic [31:0]             rdata;
        logic [1:0]              rresp;
        logic [1:0]              bresp;
        logic [1:0]              ists;
        logic [1:0]              imask;
        logic [15:0]             cnt;
        logic [BUF_AW-1:0]       addr;
        cdhp_pkg::cdhp_xfer_e    st;
        logic [5:0]              gap;
        logic [7:0]              dout;
        logic                    last;
        logic                    stat_rdy;
        logic [SW-1:0]           stat_ptr;
        logic [STAT_BYTES*8-1:0] stat;
        logic                    host_oe;
    } cdhp_state_s;
    cdhp_state_s s_r;
    cdhp_state_s s_nxt;

    // Command queue between host and controller.
    cdhp_fifo_if cq ();
    cdhp_cmd_fifo #(.DEPTH(8)) u_fifo (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .q         (cq)
    );

    logic host_wr_edge;
    logic host_rd_edge;
    logic host_rd_low;
    logic host_rd_rise;
    logic wr_go;
    logic rd_go;
    logic [31:0] rd_val;
    logic [1:0]  rd_resp;
    logic [1:0]  ev;

    // Edge detect on the synchronised strobes; stage 0 feeds stage 1 only.
    assign host_wr_edge = s_r.wsync[2] && !s_r.wsync[1];
    assign host_rd_edge = s_r.rsync[2] && !s_r.rsync[1];
    assign host_rd_rise = !s_r.rsync[2] && s_r.rsync[1];
    assign host_rd_low  = !s_r.rsync[1];
    // Host write to the command path only when select says command.
    assign cq.push      = host_wr_edge && s_r.csync[1];
    assign cq.push_data = s_r.hd2;
    assign wr_go = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    assign rd_go = s_axi_arvalid && !s_r.rvalid;
    assign cq.pop = rd_go && hit(s_axi_araddr, `CDHP_OFS_CMD_DATA);

    // Read decode for the controller bus.
    always_comb begin
        rd_val  = 32'h0000_0000;
        rd_resp = 2'b00;
        if (hit(s_axi_araddr, `CDHP_OFS_CMD_DATA)) begin
            rd_val = {24'h00_0000, cq.pop_data};
        end else if (hit(s_axi_araddr, `CDHP_OFS_CMD_STAT)) begin
            rd_val = {26'h000_0000, cq.full, !cq.empty, cq.count};
        end else if (hit(s_axi_araddr, `CDHP_OFS_XFER_CNT)) begin
            rd_val = {16'h0000, s_r.cnt};
        end else if (hit(s_axi_araddr, `CDHP_OFS_XFER_ADDR)) begin
            rd_val = 32'(s_r.addr);
        end else if (hit(s_axi_araddr, `CDHP_OFS_XFER_STAT)) begin
            rd_val = {31'h0000_0000, s_r.st != cdhp_pkg::CDHP_IDLE};
        end else if (hit(s_axi_araddr, `CDHP_OFS_IRQ_STAT)) begin
            rd_val = {30'h0000_0000, s_r.ists};
        end else if (hit(s_axi_araddr, `CDHP_OFS_IRQ_MASK)) begin
            rd_val = {30'h0000_0000, s_r.imask};
        end else if (hit(s_axi_araddr, `CDHP_OFS_STAT_CTRL)) begin
            rd_val = {27'h000_0000, 4'(s_r.stat_ptr), s_r.stat_rdy};
        end else if (s_axi_araddr >= `CDHP_OFS_STAT_BASE &&
                     s_axi_araddr < `CDHP_OFS_STAT_BASE + 12'(STAT_BYTES * 4)) begin
            rd_val = {24'h00_0000, s_r.stat[8*(s_axi_araddr[5:2])+:8]};
        end else begin
            rd_resp = 2'b10;
        end
    end

    // Next state of everything.
    always_comb begin
        s_nxt = s_r;
        ev    = 2'b00;
        // Two-flop input synchronisers with a third stage for edges.
        s_nxt.wsync = {s_r.wsync[1:0], host_write_strobe_n_i};
        s_nxt.rsync = {s_r.rsync[1:0], host_read_strobe_n_i};
        s_nxt.csync = {s_r.csync[0], command_data_select_i};
        s_nxt.msync = {s_r.msync[0], request_mode_select_i};
        s_nxt.hd1   = host_data_i;
        s_nxt.hd2   = s_r.hd1;
        // Capture write address and data in either order.
        if (s_axi_awvalid && !s_r.aw_got) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.aw_a   = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_r.w_got) begin
            s_nxt.w_got = 1'b1;
            s_nxt.w_d   = s_axi_wdata;
            // Strobes belong to the data beat; the master may drop them once it is taken.
            s_nxt.w_s   = s_axi_wstrb[1:0];
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (rd_go) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata  = rd_val;
            s_nxt.rresp  = rd_resp;
        end
        if (cq.push) begin
            ev[`CDHP_IRQ_CMD] = 1'b1;
        end
        // Controller register writes.
        if (wr_go) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = 2'b00;
            if (hit(s_r.aw_a, `CDHP_OFS_XFER_CNT) && s_r.w_s == 2'b11) begin
                s_nxt.cnt = s_r.w_d[15:0];
            end else if (hit(s_r.aw_a, `CDHP_OFS_XFER_ADDR)) begin
                s_nxt.addr = s_r.w_d[BUF_AW-1:0];
            end else if (hit(s_r.aw_a, `CDHP_OFS_XFER_TRIG)) begin
                // A trigger with a zero count or during a transfer is ignored.
                if (s_r.st == cdhp_pkg::CDHP_IDLE && s_r.cnt != 16'h0000) begin
                    s_nxt.st = cdhp_pkg::CDHP_FETCH;
                end
            end else if (hit(s_r.aw_a, `CDHP_OFS_IRQ_STAT)) begin
                s_nxt.ists = s_r.ists & ~s_r.w_d[1:0];
            end else if (hit(s_r.aw_a, `CDHP_OFS_IRQ_MASK)) begin
                s_nxt.imask = s_r.w_d[1:0];
            end else if (hit(s_r.aw_a, `CDHP_OFS_STAT_CTRL)) begin
                // Bit 0 publishes the status area to the host.
                s_nxt.stat_rdy = s_r.w_d[0];
                s_nxt.stat_ptr = '0;
            end else if (s_r.aw_a >= `CDHP_OFS_STAT_BASE &&
                         s_r.aw_a < `CDHP_OFS_STAT_BASE + 12'(STAT_BYTES * 4)) begin
                s_nxt.stat[8*(s_r.aw_a[5:2])+:8] = s_r.w_d[7:0];
            end else begin
                s_nxt.bresp = 2'b10;
            end
        end
        // Host status reads walk the twelve bytes while status is ready.
        if (s_r.stat_rdy && s_r.csync[1] && host_rd_edge) begin
            s_nxt.dout    = s_r.stat[8*s_r.stat_ptr+:8];
            s_nxt.host_oe = 1'b1;
        end
        if (s_r.stat_rdy && s_r.csync[1] && host_rd_rise) begin
            s_nxt.host_oe = 1'b0;
            if (s_r.stat_ptr == SW'(STAT_BYTES - 1)) begin
                s_nxt.stat_rdy = 1'b0;
                s_nxt.stat_ptr = '0;
            end else begin
                s_nxt.stat_ptr = s_r.stat_ptr + 1'b1;
            end
        end
        // Data transfer engine.
        case (s_r.st)
            cdhp_pkg::CDHP_IDLE: begin
                s_nxt.last = 1'b0;
            end
            cdhp_pkg::CDHP_FETCH: begin
                // Wait for the buffer arbiter to grant the read slot.
                if (buf_gnt_i) begin
                    s_nxt.dout = buf_data_i;
                    s_nxt.st   = cdhp_pkg::CDHP_OFFER;
                end
            end
            cdhp_pkg::CDHP_OFFER: begin
                if (!s_r.csync[1] && host_rd_edge) begin
                    s_nxt.host_oe = 1'b1;
                    s_nxt.last    = (s_r.cnt == 16'h0001);
                    s_nxt.st      = cdhp_pkg::CDHP_HOLD;
                end
            end
            cdhp_pkg::CDHP_HOLD: begin
                if (host_rd_rise) begin
                    s_nxt.host_oe = 1'b0;
                    s_nxt.last    = 1'b0;
                    s_nxt.cnt     = s_r.cnt - 16'h0001;
                    s_nxt.addr    = s_r.addr + 1'b1;
                    s_nxt.gap     = 6'(GAP_CYC);
                    s_nxt.st      = cdhp_pkg::CDHP_GAP;
                end
            end
            cdhp_pkg::CDHP_GAP: begin
                // The gap paces the host to the sustained byte rate.
                if (s_r.gap > 6'd1) begin
                    s_nxt.gap = s_r.gap - 6'd1;
                end else if (s_r.cnt == 16'h0000) begin
                    s_nxt.st = cdhp_pkg::CDHP_IDLE;
                    ev[`CDHP_IRQ_DONE] = 1'b1;
                end else begin
                    s_nxt.st = cdhp_pkg::CDHP_FETCH;
                end
            end
            default: begin
                s_nxt.st = cdhp_pkg::CDHP_IDLE;
            end
        endcase
        // Events set sticky bits; a set beats a simultaneous clear.
        s_nxt.ists = s_nxt.ists | ev;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_r          <= '0;
            s_r.wsync    <= 3'b111;
            s_r.rsync    <= 3'b111;
            s_r.imask    <= `CDHP_RST_MASK;
            s_r.cnt      <= `CDHP_RST_CNT;
            s_r.st       <= cdhp_pkg::CDHP_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Bus handshakes.
    assign s_axi_awready = !s_r.aw_got;
    assign s_axi_wready  = !s_r.w_got;
    assign s_axi_bvalid  = s_r.bvalid;
    assign s_axi_bresp   = s_r.bresp;
    assign s_axi_arready = !s_r.rvalid;
    assign s_axi_rvalid  = s_r.rvalid;
    assign s_axi_rdata   = s_r.rdata;
    assign s_axi_rresp   = s_r.rresp;
    assign irq_o = |(s_r.ists & s_r.imask);
    // Host side pins.
    assign host_data_o      = s_r.dout;
    assign host_data_oe_n_o = !s_r.host_oe;
    assign data_phase_active_n_o = (s_r.st == cdhp_pkg::CDHP_IDLE);
    assign last_byte_marker_n_o  = !(s_r.last && host_rd_low);
    assign status_ready_n_o      = !s_r.stat_rdy;
    // Wait mode: low stalls the host; request mode: high asks for a byte.
    assign throttle_or_request_out_o = s_r.msync[1] ?
        (s_r.st == cdhp_pkg::CDHP_OFFER) :
        !(s_r.st == cdhp_pkg::CDHP_FETCH || s_r.st == cdhp_pkg::CDHP_GAP);
    assign buf_addr_o = s_r.addr;
    assign buf_req_o  = (s_r.st == cdhp_pkg::CDHP_FETCH);
endmodule
`default_nettype wire

// >>> dv/cdhp_host_port_props.sv
`default_nettype none
// Watches the host port from its own pins and bus only.
module cdhp_host_port_props (
    // Clock and reset.
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    // Control bus handshakes.
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Host side, interrupt and buffer.
    input wire logic        irq_o,
    input wire logic        request_mode_select_i,
    input wire logic        data_phase_active_n_o,
    input wire logic        throttle_or_request_out_o,
    input wire logic        last_byte_marker_n_o,
    input wire logic        status_ready_n_o,
    input wire logic        buf_req_o,
    input wire logic        buf_gnt_i
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    // Read answers come one cycle after the address; both answers stand until taken.
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    marker_phase_a: assert property (!last_byte_marker_n_o |-> !data_phase_active_n_o)
        else $error("marker outside a transfer");
    // A fetch holds its request until granted, and only inside a transfer.
    buf_hold_a: assert property (buf_req_o && !buf_gnt_i |=> buf_req_o)
        else $error("fetch withdrawn early");
    fetch_phase_a: assert property (buf_req_o |-> !data_phase_active_n_o)
        else $error("fetch outside a transfer");
    // The closing gap keeps a fast host stalled until the phase ends.
    end_stall_a: assert property (!request_mode_select_i &&
        $rose(data_phase_active_n_o) |-> !$past(throttle_or_request_out_o))
        else $error("phase ended without stall");
    reset_idle_a: assert property ($fell(rst_i) |-> !irq_o && !buf_req_o &&
        data_phase_active_n_o && last_byte_marker_n_o && status_ready_n_o)
        else $error("outputs not idle after reset");
endmodule
bind cdhp_host_port cdhp_host_port_props u_props (.*);
`default_nettype wire

// >>> dv/cdhp_host_model.sv
`default_nettype none
// Far side: a host reading data bytes, and the buffer RAM behind the arbiter.
module cdhp_host_model (
    // Clock, reset and bench controls.
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        en_i,
    input  wire logic        slow_i,
    // Host pins.
    output logic             rd_n_o,
    input  wire logic [7:0]  hdata_i,
    input  wire logic        phase_n_i,
    input  wire logic        pace_i,
    input  wire logic        mark_n_i,
    // Buffer RAM port.
    input  wire logic [15:0] baddr_i,
    input  wire logic        breq_i,
    output logic             bgnt_o,
    output logic [7:0]       bdata_o,
    // Bytes as the host saw them.
    output logic [7:0]       byte_o,
    output logic             stb_o,
    output logic             last_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int   hcnt;  // Strobe sequence counter.
    int   bcnt;  // Grant delay counter.
    logic bdone; // Grant given; no second one until the request drops.
    initial {rd_n_o, bgnt_o, bdata_o} = 10'h200;
    // One strobe per byte, begun only while pacing allows it.
    always @(posedge clk_sys_i) begin
        stb_o <= 1'b0;
        if (rst_i) begin
            rd_n_o <= 1'b1;
            hcnt <= 0;
        end else if (hcnt > 0) begin
            hcnt <= hcnt - 1;
            if (hcnt == 7) begin
                rd_n_o <= 1'b1;
                byte_o <= hdata_i;
                last_o <= !mark_n_i;
                stb_o <= 1'b1;
            end
        end else if (en_i && !phase_n_i && pace_i) begin
            rd_n_o <= 1'b0;
            hcnt <= slow_i ? 16 : 12;
        end
    end
    // Data lines show a changing pattern outside a grant, so stale bytes cannot pass.
    always @(posedge clk_sys_i) begin
        bgnt_o <= 1'b0;
        bdata_o <= ~bdata_o;
        if (rst_i || !breq_i) begin
            bcnt <= slow_i ? 5 : 0;
            bdone <= 1'b0;
        end else if (bcnt > 0) begin
            bcnt <= bcnt - 1;
        end else if (!bdone) begin
            bgnt_o <= 1'b1;
            bdata_o <= baddr_i[7:0] ^ 8'h5A;
            bdone <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> dv/cdhp_host_port_tb.sv
`default_nettype none
`include "cdhp_map.svh"
module cdhp_host_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys_i, rst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, host_write_strobe_n_i, command_data_select_i, tb_rd_n, md_rd_n;
    logic        request_mode_select_i, en, slow, mstb, mlast, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o, host_data_oe_n_o, buf_gnt_i;
    logic        data_phase_active_n_o, throttle_or_request_out_o, last_byte_marker_n_o;
    logic        status_ready_n_o, buf_req_o;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  host_data_i, host_data_o, buf_data_i, mbyte, q[$], cq[9], sq[12];
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [15:0] buf_addr_o;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, d;
    logic        lq[$];
    wire logic   host_read_strobe_n_i;
    int          error_cnt, n_checks, i;
    // Bench (status reads) and model (data reads) share the host read strobe.
    assign host_read_strobe_n_i = md_rd_n & tb_rd_n;
    cdhp_host_port u_cdhp_host_port (.*);
    cdhp_host_model u_cdhp_host_model (.clk_sys_i, .rst_i, .en_i(en), .slow_i(slow),
        .rd_n_o(md_rd_n), .hdata_i(host_data_o), .phase_n_i(data_phase_active_n_o),
        .pace_i(throttle_or_request_out_o), .mark_n_i(last_byte_marker_n_o),
        .baddr_i(buf_addr_o), .breq_i(buf_req_o), .bgnt_o(buf_gnt_i), .bdata_o(buf_data_i),
        .byte_o(mbyte), .stb_o(mstb), .last_o(mlast));
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) if (mstb) begin
        q.push_back(mbyte);
        lq.push_back(mlast);
    end
    function automatic logic [31:0] cstat(input int n);
        return {26'h0, n == 8, n != 0, 4'(n)};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // Both write channels are offered together; ready is up before the answer comes, so it is taken at once.
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
        int t;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
        s_axi_bready <= 1'($random(seed));
        for (t = 0; t < 200; t++) begin
            @(posedge clk_sys_i);
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            s_axi_bready <= 1'b1;
        end
        chk("write_resp", 0, {t >= 200, s_axi_bresp});
    endtask
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rr);
        int t;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'($random(seed));
        for (t = 0; t < 200; t++) begin
            @(posedge clk_sys_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            s_axi_rready <= 1'b1;
        end
        v = s_axi_rdata;
        rr = s_axi_rresp;
        chk("read_wait", 1, t < 200);
    endtask
    task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
        axi_rd(a, d, r);
        chk(n, e, d);
    endtask
    // Command data settles before the strobe and holds across it.
    task automatic host_wr(input logic [7:0] v);
        host_data_i <= v;
        repeat (3) @(posedge clk_sys_i);
        host_write_strobe_n_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        host_write_strobe_n_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
    endtask
    // Transfer ending at the top of the 60 KB buffer space, with a random short length.
    task automatic xfer(input logic m);
        int n, t, k;
        logic [15:0] base;
        n = 2 + int'($unsigned($random(seed)) % 4);
        base = 16'hF000 - 16'(n);
        {request_mode_select_i, slow, command_data_select_i} <= {m, m, 1'b0};
        q.delete();
        lq.delete();
        axi_wr(`CDHP_OFS_XFER_CNT, 32'(n));
        axi_wr(`CDHP_OFS_XFER_ADDR, 32'(base));
        chk("phase_idle", 1, data_phase_active_n_o);
        axi_wr(`CDHP_OFS_XFER_TRIG, 32'h0000_0001);
        repeat (2) @(posedge clk_sys_i);
        chk("phase_on", 0, data_phase_active_n_o);
        rdchk("busy", `CDHP_OFS_XFER_STAT, 1);
        en <= 1'b1;
        for (t = 0; t < 5000 && data_phase_active_n_o === 1'b0; t++) @(posedge clk_sys_i);
        en <= 1'b0;
        chk("xfer_len", n, q.size());
        for (k = 0; k < n && k < q.size(); k++) begin
            chk("xfer_byte", base[7:0] + 8'(k) ^ 8'h5A, q[k]);
            chk("xfer_last", k == n - 1, lq[k]);
        end
        repeat (2) @(posedge clk_sys_i);
        chk("done_irq", 1, irq_o);
        rdchk("done_stat", `CDHP_OFS_IRQ_STAT, 32'h0000_0002);
        axi_wr(`CDHP_OFS_IRQ_STAT, 32'h0000_0002);
        $display("test transfer mode %0d done", m);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // A hang past the expected span counts as a mismatch.
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        error_cnt++;
        close_out();
    end
    initial begin
        seed = 32'h2497;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, en, slow} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, host_data_i, request_mode_select_i} = '0;
        {host_write_strobe_n_i, tb_rd_n, command_data_select_i, rst_i, s_axi_wstrb} = '1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        rdchk("mask_reset", `CDHP_OFS_IRQ_MASK, 32'(`CDHP_RST_MASK));
        rdchk("cnt_reset", `CDHP_OFS_XFER_CNT, 32'(`CDHP_RST_CNT));
        axi_rd(12'h3FC, d, r);
        chk("unmapped_resp", 2, r);
        for (i = 0; i < 9; i++) begin
            cq[i] = 8'($random(seed));
            host_wr(cq[i]);
        end
        chk("irq_masked", 0, irq_o);
        axi_wr(`CDHP_OFS_IRQ_MASK, 32'h0000_0003);
        repeat (2) @(posedge clk_sys_i);
        chk("irq_cmd", 1, irq_o);
        rdchk("cmd_full", `CDHP_OFS_CMD_STAT, cstat(8));
        for (i = 0; i < 8; i++) rdchk("cmd_byte", `CDHP_OFS_CMD_DATA, 32'(cq[i]));
        rdchk("cmd_empty", `CDHP_OFS_CMD_STAT, cstat(0));
        axi_wr(`CDHP_OFS_IRQ_STAT, 32'h0000_0001);
        repeat (2) @(posedge clk_sys_i);
        chk("irq_clear", 0, irq_o);
        $display("test commands done");
        for (i = 0; i < 12; i++) begin
            sq[i] = 8'($random(seed));
            axi_wr(12'(`CDHP_OFS_STAT_BASE + 4 * i), 32'(sq[i]));
        end
        axi_wr(`CDHP_OFS_STAT_CTRL, 32'h0000_0001);
        repeat (2) @(posedge clk_sys_i);
        chk("status_ready", 0, status_ready_n_o);
        for (i = 0; i < 12; i++) begin
            tb_rd_n <= 1'b0;
            repeat (6) @(posedge clk_sys_i);
            chk("status_byte", sq[i], host_data_o);
            chk("status_oe", 0, host_data_oe_n_o);
            tb_rd_n <= 1'b1;
            repeat (6) @(posedge clk_sys_i);
        end
        chk("status_taken", 1, status_ready_n_o);
        $display("test status done");
        xfer(1'b0);
        xfer(1'b1);
        close_out();
    end
endmodule
`default_nettype wire
